// *** hdl/cvf_pkg.sv ***
package cvf_pkg;
    localparam int IMG_W      = 8;
    localparam int IMG_H      = 8;
    localparam int PIX_W      = 8;
    localparam int COEF_W     = 9;
    localparam int COL_W      = 3;
    localparam int SUM_W      = 21;
    localparam int NUM_LINES  = 3;
    localparam int NUM_TAPS   = 9;
    localparam int FIFO_DEPTH = 8;
    localparam logic [COL_W-1:0] LAST_COL = 3'h7;
    localparam logic [COL_W-1:0] LAST_ROW = 3'h7;
    localparam logic [1:0]       LAST_BUF = 2'h2;

    typedef logic signed [COEF_W-1:0] cvf_coef_t;

    typedef struct packed {
        logic [PIX_W-1:0] pix;
        logic             sof;
    } cvf_pix_t;

    typedef struct packed {
        logic signed [SUM_W-1:0] sum;
        logic                    sof;
    } cvf_out_t;

    localparam int OUT_W = SUM_W + 1;
endpackage

// *** hdl/cvf_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module cvf_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 8
) (
    // Clock, reset, enable
    input  wire logic             CLK_SYS_I,
    input  wire logic             RESET_I,
    input  wire logic             CE_I,
    // Write side
    input  wire logic             IN_VALID_I,
    output logic                  IN_READY_O,
    input  wire logic [WIDTH-1:0] IN_DATA_I,
    // Read side
    output logic                  OUT_VALID_O,
    input  wire logic             OUT_READY_I,
    output logic      [WIDTH-1:0] OUT_DATA_O
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = IN_VALID_I && (count != (AW+1)'(DEPTH));
    wire              pop  = OUT_READY_I && (count != '0);

    assign IN_READY_O  = (count != (AW+1)'(DEPTH));
    assign OUT_VALID_O = (count != '0);
    assign OUT_DATA_O  = mem[rd_ptr];

    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (CE_I) begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage has no reset; only pointers and count matter
    always_ff @(posedge CLK_SYS_I) begin
        if (CE_I && push) begin
            mem[wr_ptr] <= IN_DATA_I;
        end
    end
endmodule
`default_nettype wire

// *** hdl/cvf_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
module cvf_filter
    import cvf_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  RESET_I,
    input  wire logic                  CE_I,
    // Weights and mode
    input  wire cvf_pkg::cvf_coef_t    WEIGHT_I [cvf_pkg::NUM_TAPS],
    input  wire logic                  SYM_MODE_I,
    // Pixel input
    input  wire logic                  PIX_VALID_I,
    output logic                       PIX_READY_O,
    input  wire logic [cvf_pkg::PIX_W-1:0] PIX_I,
    // Filtered output
    output logic                       OUT_VALID_O,
    input  wire logic                  OUT_READY_I,
    output logic signed [cvf_pkg::SUM_W-1:0] OUT_PIX_O,
    output logic                       OUT_SOF_O
);
    import cvf_pkg::*;

    typedef enum logic [1:0] {FILL, FLUSH} cvf_state_t;

    cvf_state_t       state;
    logic [PIX_W-1:0] line_mem [NUM_LINES][IMG_W];
    logic [6:0]       in_cnt;
    logic [5:0]       out_cnt;
    logic [1:0]       wr_buf;
    logic [1:0]       ctr_buf;
    cvf_out_t         res;

    // Output stage and FIFO
    logic     fifo_in_ready;
    logic     fifo_out_valid;
    cvf_out_t fifo_out_data;
    logic     out_valid_q;
    cvf_out_t out_q;

    // Counters double as row and column of the next pixel in and out
    wire [COL_W-1:0] in_col  = in_cnt[2:0];
    wire [COL_W-1:0] out_col = out_cnt[2:0];
    wire [COL_W-1:0] out_row = out_cnt[5:3];
    wire             in_take = PIX_VALID_I && PIX_READY_O;
    // Last reader of a slot is the output one column right, two rows up
    wire [7:0] in_need   = {1'b0, in_cnt} + ((in_col == LAST_COL) ? 8'h00 : 8'h01);
    wire       slot_ok   = in_need < ({2'b00, out_cnt} + 8'h10);
    // An output needs the pixel right of it on the row below
    wire [7:0] out_reach = {2'b00, out_cnt} + ((out_col == LAST_COL) ? 8'h09 : 8'h0A);
    wire [7:0] out_need  = (out_reach > 8'h40) ? 8'h40 : out_reach;
    wire       can_emit  = ({1'b0, in_cnt} >= out_need) && fifo_in_ready;
    assign PIX_READY_O = (state == FILL) && slot_ok;

    // Row memory selection by rotation
    wire [1:0] buf_up = (ctr_buf == 2'h0) ? LAST_BUF : ctr_buf - 2'h1;
    wire [1:0] buf_dn = (ctr_buf == LAST_BUF) ? 2'h0 : ctr_buf + 2'h1;

    // Neighbourhood window with zero padding
    logic [PIX_W-1:0] win [NUM_TAPS];
    genvar g;
    generate
        for (g = 0; g < NUM_TAPS; g++) begin : g_win
            localparam int DR = g / 3 - 1;
            localparam int DC = g % 3 - 1;
            wire [1:0]       sel_buf = (DR < 0) ? buf_up : (DR > 0) ? buf_dn : ctr_buf;
            wire [COL_W-1:0] sel_col = out_col + COL_W'(DC);
            wire             outside = ((DR < 0) && (out_row == '0)) ||
                                       ((DR > 0) && (out_row == LAST_ROW)) ||
                                       ((DC < 0) && (out_col == '0)) ||
                                       ((DC > 0) && (out_col == LAST_COL));
            assign win[g] = outside ? '0 : line_mem[sel_buf][sel_col];
        end
    endgenerate

    // Parallel products and sum
    logic signed [SUM_W-1:0] prod [NUM_TAPS];
    generate
        for (g = 0; g < NUM_TAPS; g++) begin : g_mul
            wire signed [PIX_W+1:0]  pix_s = $signed({2'b00, win[g]});
            wire signed [COEF_W-1:0] w     = WEIGHT_I[g];
            assign prod[g] = SUM_W'(pix_s * w);
        end
    endgenerate

    // Symmetric variant: corners and edges pre-added, centre weighted alone
    wire signed [SUM_W-1:0] sum_corner = SUM_W'({1'b0, win[0]}) + SUM_W'({1'b0, win[2]}) +
                                         SUM_W'({1'b0, win[6]}) + SUM_W'({1'b0, win[8]});
    wire signed [SUM_W-1:0] sum_edge   = SUM_W'({1'b0, win[1]}) + SUM_W'({1'b0, win[3]}) +
                                         SUM_W'({1'b0, win[5]}) + SUM_W'({1'b0, win[7]});
    wire signed [SUM_W-1:0] sym_sum    = SUM_W'(sum_corner * SUM_W'(WEIGHT_I[2])) +
                                         SUM_W'(sum_edge * SUM_W'(WEIGHT_I[1])) +
                                         SUM_W'($signed({1'b0, win[4]}) * WEIGHT_I[0]);
    wire signed [SUM_W-1:0] full_sum   = prod[0] + prod[1] + prod[2] + prod[3] + prod[4] +
                                         prod[5] + prod[6] + prod[7] + prod[8];
    wire signed [SUM_W-1:0] next_sum   = SYM_MODE_I ? sym_sum : full_sum;
    // Straight into the buffer so its ready covers every result in flight
    assign res = '{sum: next_sum, sof: (out_cnt == 6'h00)};

    wire last_out = (out_row == LAST_ROW) && (out_col == LAST_COL);

    // Input side: write and rotation
    always_ff @(posedge CLK_SYS_I) begin
        if (CE_I && in_take) begin
            line_mem[wr_buf][in_col] <= PIX_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            in_cnt  <= '0;
            wr_buf  <= '0;
            out_cnt <= '0;
            ctr_buf <= '0;
            state   <= FILL;
        end else if (CE_I) begin
            if (in_take) begin
                in_cnt <= in_cnt + 7'h01;
                if (in_col == LAST_COL) begin
                    wr_buf <= (wr_buf == LAST_BUF) ? 2'h0 : wr_buf + 2'h1;
                end
            end
            if (can_emit) begin
                out_cnt <= out_cnt + 6'h01;
                if (out_col == LAST_COL) begin
                    ctr_buf <= buf_dn;
                end
            end
            case (state)
                FILL: begin
                    if (in_take && in_cnt == 7'h3F) begin
                        state <= FLUSH;
                    end
                end
                FLUSH: begin
                    // Last output frees every row memory; next pixel is top-left
                    if (can_emit && last_out) begin
                        state   <= FILL;
                        in_cnt  <= '0;
                        wr_buf  <= '0;
                        ctr_buf <= '0;
                    end
                end
                default: state <= FILL;
            endcase
        end
    end

    // Buffer keeps results while the consumer stalls; its ready stalls can_emit
    cvf_fifo #(
        .WIDTH (OUT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .CLK_SYS_I   (CLK_SYS_I),
        .RESET_I     (RESET_I),
        .CE_I        (CE_I),
        .IN_VALID_I  (can_emit),
        .IN_READY_O  (fifo_in_ready),
        .IN_DATA_I   (res),
        .OUT_VALID_O (fifo_out_valid),
        .OUT_READY_I (!out_valid_q || OUT_READY_I),
        .OUT_DATA_O  (fifo_out_data)
    );

    // Registered output stage
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            out_valid_q <= 1'b0;
            out_q       <= '0;
        end else if (CE_I) begin
            if (!out_valid_q || OUT_READY_I) begin
                out_valid_q <= fifo_out_valid;
                out_q       <= fifo_out_data;
            end
        end
    end

    assign OUT_VALID_O = out_valid_q;
    assign OUT_PIX_O   = out_q.sum;
    assign OUT_SOF_O   = out_q.sof;
endmodule
`default_nettype wire

// *** sim/cvf_sink_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cvf_sink_model
    import cvf_pkg::*;
(
    // Clock and enable
    input  wire logic                           clk_i,
    input  wire logic                           ce_i,
    // Filtered stream
    input  wire logic                           valid_i,
    input  wire logic signed [cvf_pkg::SUM_W-1:0] pix_i,
    input  wire logic                           sof_i,
    output logic                                ready_o,
    // Stall request from the bench
    input  wire logic                           stall_i
);
    logic                    rdy  = 1'b0;
    integer                  seed = 41166;
    logic signed [SUM_W-1:0] got_pix [$];
    logic                    got_sof [$];
    // Gated by enable so a take never lands on a frozen edge
    assign ready_o = rdy & ce_i;
    always @(negedge clk_i) begin
        rdy <= stall_i ? (($random(seed) & 3) == 0) : 1'b1;
    end
    always @(posedge clk_i) begin
        if (valid_i && ready_o) begin
            got_pix.push_back(pix_i);
            got_sof.push_back(sof_i);
        end
    end
endmodule
`default_nettype wire

// *** sim/cvf_filter_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module cvf_filter_checker
    import cvf_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                           CLK_SYS_I,
    input  wire logic                           RESET_I,
    input  wire logic                           CE_I,
    // Streams
    input  wire logic                           PIX_VALID_I,
    input  wire logic                           PIX_READY_O,
    input  wire logic                           OUT_VALID_O,
    input  wire logic                           OUT_READY_I,
    input  wire logic signed [cvf_pkg::SUM_W-1:0] OUT_PIX_O,
    input  wire logic                           OUT_SOF_O
);
    int in_tot;
    int out_tot;
    int low_run;
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            in_tot  <= 0;
            out_tot <= 0;
            low_run <= 0;
        end else begin
            if (CE_I && PIX_VALID_I && PIX_READY_O)
                in_tot <= in_tot + 1;
            if (OUT_VALID_O && OUT_READY_I)
                out_tot <= out_tot + 1;
            low_run <= (PIX_READY_O || !OUT_READY_I || !CE_I) ? 0 : low_run + 1;
        end
    end
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RESET_I);
    AST_RDY_AFTER_RST: assert property ($past(RESET_I) |-> PIX_READY_O && !OUT_VALID_O)
        else $error("not idle after reset");
    AST_OUT_HOLD: assert property (OUT_VALID_O && !OUT_READY_I |=>
        OUT_VALID_O && $stable(OUT_PIX_O) && $stable(OUT_SOF_O))
        else $error("output changed while stalled");
    AST_CE_FREEZE: assert property (!CE_I |=> $stable(OUT_VALID_O) && $stable(PIX_READY_O))
        else $error("state moved with enable low");
    AST_SOF_POS: assert property (OUT_VALID_O |-> OUT_SOF_O == (out_tot[5:0] == 0))
        else $error("start marker misplaced");
    AST_CAUSAL: assert property (OUT_VALID_O && out_tot[5:3] != 3'h7 |-> in_tot >= out_tot + 8)
        else $error("output before row below arrived");
    AST_TRAIL: assert property (OUT_VALID_O |-> out_tot < in_tot)
        else $error("more outputs than inputs");
    AST_RANGE: assert property (OUT_VALID_O |-> OUT_PIX_O >= -587520 && OUT_PIX_O <= 585225)
        else $error("sum outside nine-product range");
    AST_FLUSH: assert property (low_run < 64)
        else $error("input refused too long");
    cover property (OUT_VALID_O && OUT_SOF_O && OUT_READY_I);
    cover property (OUT_VALID_O && !OUT_READY_I);
    cover property (PIX_VALID_I && !PIX_READY_O);
endmodule
bind cvf_filter cvf_filter_checker u_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .CE_I(CE_I),
    .PIX_VALID_I(PIX_VALID_I), .PIX_READY_O(PIX_READY_O), .OUT_VALID_O(OUT_VALID_O),
    .OUT_READY_I(OUT_READY_I), .OUT_PIX_O(OUT_PIX_O), .OUT_SOF_O(OUT_SOF_O));
`default_nettype wire

// *** sim/cvf_filter_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module cvf_filter_test;
    import cvf_pkg::*;
    logic                    clk   = 1'b0;
    logic                    rst   = 1'b1;
    logic                    ce    = 1'b1;
    logic                    sym   = 1'b0;
    logic                    pvld  = 1'b0;
    logic                    stall = 1'b0;
    logic [PIX_W-1:0]        pix   = 8'h00;
    cvf_coef_t               w [NUM_TAPS];
    logic                    prdy;
    logic                    oval;
    logic                    ordy;
    logic                    osof;
    logic signed [SUM_W-1:0] opix;
    integer                  seed = 41166;
    int                      fail_count = 0;
    int                      num_checks = 0;
    int                      img [64];
    int                      exp_q [$];
    cvf_filter dut (.CLK_SYS_I(clk), .RESET_I(rst), .CE_I(ce), .WEIGHT_I(w), .SYM_MODE_I(sym),
        .PIX_VALID_I(pvld), .PIX_READY_O(prdy), .PIX_I(pix), .OUT_VALID_O(oval),
        .OUT_READY_I(ordy), .OUT_PIX_O(opix), .OUT_SOF_O(osof));
    cvf_sink_model u_sink (.clk_i(clk), .ce_i(ce), .valid_i(oval), .pix_i(opix), .sof_i(osof),
        .ready_o(ordy), .stall_i(stall));
    initial forever #5 clk = ~clk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic model();
        int s;
        int x;
        int k;
        for (int r = 0; r < 8; r++)
            for (int c = 0; c < 8; c++) begin
                s = 0;
                for (int dr = -1; dr <= 1; dr++)
                    for (int dc = -1; dc <= 1; dc++) begin
                        x = (r+dr < 0 || r+dr > 7 || c+dc < 0 || c+dc > 7) ? 0 : img[(r+dr)*8+c+dc];
                        k = !sym ? (dr+1)*3+dc+1 : (dr == 0 && dc == 0) ? 0 : (dr == 0 || dc == 0) ? 1 : 2;
                        s += int'(w[k]) * x;
                    end
                exp_q.push_back(s);
            end
    endtask
    task automatic setw(input int mode, input logic s);
        @(negedge clk);
        sym = s;
        for (int i = 0; i < 9; i++)
            w[i] = mode ? ((i % 2) ? 9'h100 : 9'h0FF) : 9'($random(seed));
    endtask
    // Pixels go in raster order with random gaps and enable drops
    task automatic send(input int mode, input int n);
        for (int i = 0; i < 64; i++)
            img[i] = mode == 0 ? ($random(seed) & 255) : mode == 1 ? 255 : (i % 2) * 255;
        if (n == 64)
            model();
        for (int i = 0; i < n; i++) begin
            do begin
                @(negedge clk);
                ce = ($random(seed) & 7) != 0;
                pvld = ce && (($random(seed) & 3) != 0);
                pix = img[i][7:0];
                @(posedge clk);
            end while (!(pvld && prdy && ce));
        end
        @(negedge clk);
        pvld = 1'b0;
        ce = 1'b1;
    endtask
    task automatic drain();
        int n;
        n = exp_q.size();
        for (int t = 0; t < 3000 && u_sink.got_pix.size() < n; t++)
            @(posedge clk);
        repeat (20) @(posedge clk);
        chk(u_sink.got_pix.size(), n);
        for (int i = 0; i < n && i < u_sink.got_pix.size(); i++) begin
            chk(32'(u_sink.got_pix[i]), exp_q[i]);
            chk(u_sink.got_sof[i], i % 64 == 0);
        end
        u_sink.got_pix.delete();
        u_sink.got_sof.delete();
        exp_q.delete();
    endtask
    initial begin
        for (int i = 0; i < 9; i++)
            w[i] = 9'h000;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        setw(0, 1'b0);
        send(0, 64);
        drain();
        // Full-scale pixels against extreme weights, back to back
        setw(1, 1'b0);
        send(1, 64);
        send(2, 64);
        drain();
        setw(0, 1'b1);
        send(0, 64);
        drain();
        // Slow consumer fills the buffer and forces refusals
        stall = 1'b1;
        setw(0, 1'b0);
        send(0, 64);
        send(2, 64);
        drain();
        stall = 1'b0;
        // Reset part way through an image
        send(0, 20);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        u_sink.got_pix.delete();
        u_sink.got_sof.delete();
        send(0, 64);
        drain();
        wrap_up();
    end
    initial begin
        #500000;
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
